// >>> hw/chjc_pkg.sv
/*
 Constants for the collision, heartbeat and jabber control block.
 Assumes a 100 MHz system clock; all intervals are derived from it.
*/
package chjc_pkg;
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned OSC_MHZ       = 10;
	// Half period of the 10 MHz collision square wave
	localparam int unsigned OSC_HALF_CYC  = CLK_MHZ / (2 * OSC_MHZ);
	localparam int unsigned TX_END_NS     = 300;
	localparam int unsigned TX_END_CYC    = (TX_END_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned HB_DELAY_NS   = 1100;
	localparam int unsigned HB_DELAY_CYC  = (HB_DELAY_NS * CLK_MHZ) / 1000;
	localparam int unsigned HB_WIDTH_NS   = 1000;
	localparam int unsigned HB_WIDTH_CYC  = (HB_WIDTH_NS * CLK_MHZ) / 1000;
	localparam int unsigned JAB_MS        = 20;
	localparam int unsigned UNJAB_MS      = 500;
	// Jabber intervals count 10 MHz oscillator ticks
	localparam int unsigned JAB_TICKS     = JAB_MS * OSC_MHZ * 1000;
	localparam int unsigned UNJAB_TICKS   = UNJAB_MS * OSC_MHZ * 1000;
	localparam int unsigned CNT_W         = 24;
	localparam int unsigned OSC_W         = 4;

	typedef enum logic [2:0] {
		CHJC_HB_IDLE  = 3'h1,
		CHJC_HB_WAIT  = 3'h2,
		CHJC_HB_BURST = 3'h4
	} chjc_hb_t;

	typedef enum logic [2:0] {
		CHJC_JB_RUN   = 3'h1,
		CHJC_JB_FAULT = 3'h2,
		CHJC_JB_UNJAB = 3'h4
	} chjc_jb_t;
endpackage : chjc_pkg

// >>> hw/chjc_top.sv
/*
 Collision, heartbeat and jabber control of a coax transceiver.
 Assumes the analog front end provides squelch-qualified digital levels:
 tx_active_in (transmit pair beyond squelch) and a collision comparator result.
*/
// Functional notes
// R1 - Collision comparator result raises collision indication
// R2 - Heartbeat 1.1 us after transmit end, 1 us
// R3 - Heartbeat only when enable pin grounded
// R4 - Internal 10 MHz oscillator is jabber timebase
// R5 - Square wave on collision pair during events
// R6 - Collision pair idles at zero differential
// R7 - Over 20 ms activity inhibits drive, faults
// R8 - Collision output active while jabber fault persists
// R9 - Unjab wait 500 ms before re-enabling transmitter
// R10 - Partner keeps transmit idle during unjab
// R11 - Only squelch-qualified activity reaches coax drive
// R12 - Transmit end after 300 ns inactivity
// R13 - Power-up idle, transmitter enabled, output quiet
// R14 - Jabber count restarts at each new transmission
`timescale 1ns/1ps
module chjc_top
	import chjc_pkg::*;
(
	input  wire logic clk_sys,              // 100 MHz system clock
	input  wire logic rst_n,                // Asynchronous reset, active low
	input  wire logic tx_active_in,         // Transmit pair beyond squelch level
	input  wire logic collision_cmp_in,     // Center level below shield_sense_in by threshold
	input  wire logic heartbeat_enable_pin, // High when pin at ground level
	output logic      coax_drive_out,       // Drive to coax output stage
	output logic      collision_out_pair,   // Collision pair, positive leg
	output logic      collision_out_pair_n, // Collision pair, negative leg
	output logic      jabber_fault_q        // Jabber fault in progress
);
	logic rst_s1_q, rst_s2_q;
	logic tx_s1_q, tx_s2_q, col_s1_q, col_s2_q, hbe_s1_q, hbe_s2_q;
	logic [OSC_W-1:0] osc_div_q;
	logic             osc_q;
	logic             osc_tick;
	logic             osc_rise;
	logic             xmit_q;
	logic [CNT_W-1:0] idle_cnt_q;
	logic             tx_end;
	chjc_hb_t         hb_q;
	logic [CNT_W-1:0] hb_cnt_q;
	chjc_jb_t         jb_q;
	logic [CNT_W-1:0] jb_cnt_q;
	logic             cd_active;
	logic             drive_d;
	// Last cycle index of a heartbeat burst, for the width check
	localparam int    HB_BURST_LAST = int'(HB_WIDTH_CYC) - 1;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			tx_s1_q  <= 1'b0;
			tx_s2_q  <= 1'b0;
			col_s1_q <= 1'b0;
			col_s2_q <= 1'b0;
			hbe_s1_q <= 1'b0;
			hbe_s2_q <= 1'b0;
		end else begin
			tx_s1_q  <= tx_active_in;
			tx_s2_q  <= tx_s1_q;
			col_s1_q <= collision_cmp_in;
			col_s2_q <= col_s1_q;
			hbe_s1_q <= heartbeat_enable_pin;
			hbe_s2_q <= hbe_s1_q;
		end
	end

	// Free-running 10 MHz oscillator [R4]
	assign osc_tick = (osc_div_q == OSC_W'(OSC_HALF_CYC - 1));
	assign osc_rise = osc_tick && !osc_q;
	always_ff @(posedge clk_sys or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			osc_div_q <= '0;
			osc_q     <= 1'b0;
		end else begin
			osc_div_q <= osc_tick ? '0 : osc_div_q + OSC_W'(1);
			osc_q     <= osc_tick ? ~osc_q : osc_q;
		end
	end

	// Transmission start on activity, end after quiet interval [R12]
	assign tx_end = xmit_q && !tx_s2_q && (idle_cnt_q == CNT_W'(TX_END_CYC - 1));
	always_ff @(posedge clk_sys or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			xmit_q     <= 1'b0;
			idle_cnt_q <= '0;
		end else begin
			idle_cnt_q <= (tx_s2_q || !xmit_q) ? '0 : idle_cnt_q + CNT_W'(1);
			xmit_q     <= tx_s2_q ? 1'b1 : (tx_end ? 1'b0 : xmit_q);
		end
	end

	// Heartbeat sequencer [R2] [R3]
	always_ff @(posedge clk_sys or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			hb_q     <= CHJC_HB_IDLE;
			hb_cnt_q <= '0;
		end else begin
			unique case (hb_q)
				CHJC_HB_IDLE: begin
					hb_cnt_q <= '0;
					if (tx_end && hbe_s2_q) begin
						hb_q <= CHJC_HB_WAIT;
					end
				end
				CHJC_HB_WAIT: begin
					hb_cnt_q <= hb_cnt_q + CNT_W'(1);
					if (hb_cnt_q == CNT_W'(HB_DELAY_CYC - TX_END_CYC - 1)) begin
						hb_q     <= CHJC_HB_BURST;
						hb_cnt_q <= '0;
					end
				end
				CHJC_HB_BURST: begin
					hb_cnt_q <= hb_cnt_q + CNT_W'(1);
					if (hb_cnt_q == CNT_W'(HB_WIDTH_CYC - 1)) begin
						hb_q     <= CHJC_HB_IDLE;
						hb_cnt_q <= '0;
					end
				end
				default: begin
					hb_q     <= CHJC_HB_IDLE;
					hb_cnt_q <= '0;
				end
			endcase
		end
	end

	// Jabber timer counted in oscillator ticks on the rising half [R4]
	always_ff @(posedge clk_sys or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			jb_q     <= CHJC_JB_RUN;
			jb_cnt_q <= '0;
		end else begin
			unique case (jb_q)
				CHJC_JB_RUN: begin
					if (!xmit_q) begin
						jb_cnt_q <= '0; // [R14]
					end else if (osc_rise) begin
						jb_cnt_q <= jb_cnt_q + CNT_W'(1);
						if (jb_cnt_q == CNT_W'(JAB_TICKS - 1)) begin
							jb_q     <= CHJC_JB_FAULT; // [R7]
							jb_cnt_q <= '0;
						end
					end
				end
				CHJC_JB_FAULT: begin
					jb_cnt_q <= '0;
					if (!xmit_q) begin
						jb_q <= CHJC_JB_UNJAB;
					end
				end
				CHJC_JB_UNJAB: begin
					// Activity during unjab is not allowed; it restarts the wait [R10]
					if (tx_s2_q) begin
						jb_cnt_q <= '0;
					end else if (osc_rise) begin
						jb_cnt_q <= jb_cnt_q + CNT_W'(1);
						if (jb_cnt_q == CNT_W'(UNJAB_TICKS - 1)) begin
							jb_q     <= CHJC_JB_RUN; // [R9]
							jb_cnt_q <= '0;
						end
					end
				end
				default: begin
					jb_q     <= CHJC_JB_RUN;
					jb_cnt_q <= '0;
				end
			endcase
		end
	end

	assign cd_active = col_s2_q || (jb_q == CHJC_JB_FAULT) || (hb_q == CHJC_HB_BURST); // [R1] [R8]
	assign drive_d   = tx_s2_q && (jb_q == CHJC_JB_RUN) && (jb_cnt_q != CNT_W'(JAB_TICKS - 1)); // [R11]

	// Square wave while active, both legs low (zero differential) at rest [R5] [R6] [R13]
	always_ff @(posedge clk_sys or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			coax_drive_out       <= 1'b0;
			collision_out_pair   <= 1'b0;
			collision_out_pair_n <= 1'b0;
			jabber_fault_q       <= 1'b0;
		end else begin
			coax_drive_out       <= drive_d;
			collision_out_pair   <= cd_active && osc_q;
			collision_out_pair_n <= cd_active && !osc_q;
			jabber_fault_q       <= (jb_q == CHJC_JB_FAULT);
		end
	end

	property p_rest_zero;
		@(posedge clk_sys) disable iff (!rst_s2_q)
		!cd_active |=> !(collision_out_pair ^ collision_out_pair_n);
	endproperty
	a_rest_zero: assert property (p_rest_zero) else $error("pair not at rest"); // [R6]

	property p_legs_excl;
		@(posedge clk_sys) disable iff (!rst_s2_q)
		!(collision_out_pair && collision_out_pair_n);
	endproperty
	a_legs_excl: assert property (p_legs_excl) else $error("both legs high"); // [R5]

	property p_fault_blocks;
		@(posedge clk_sys) disable iff (!rst_s2_q)
		jb_q != CHJC_JB_RUN |=> !coax_drive_out;
	endproperty
	a_fault_blocks: assert property (p_fault_blocks) else $error("drive during jabber"); // [R7] [R9]

	property p_fault_cd;
		@(posedge clk_sys) disable iff (!rst_s2_q)
		jb_q == CHJC_JB_FAULT |-> ##[1:12] (collision_out_pair || collision_out_pair_n);
	endproperty
	a_fault_cd: assert property (p_fault_cd) else $error("no cd"); // [R8]

	property p_hb_gate;
		@(posedge clk_sys) disable iff (!rst_s2_q)
		(hb_q == CHJC_HB_IDLE && tx_end && !hbe_s2_q) |=> hb_q == CHJC_HB_IDLE;
	endproperty
	a_hb_gate: assert property (p_hb_gate) else $error("hb not gated"); // [R3]

	// Burst entry, then burst held to its last cycle and back to idle
	sequence s_hb_start;
		$rose(hb_q == CHJC_HB_BURST);
	endsequence
	sequence s_hb_finish;
		##HB_BURST_LAST (hb_q == CHJC_HB_BURST) ##1 (hb_q == CHJC_HB_IDLE);
	endsequence
	property p_hb_width;
		@(posedge clk_sys) disable iff (!rst_s2_q)
		s_hb_start |-> s_hb_finish;
	endproperty
	a_hb_width: assert property (p_hb_width) else $error("hb width"); // [R2]

	property p_qual;
		@(posedge clk_sys) disable iff (!rst_s2_q)
		coax_drive_out |-> $past(tx_s2_q);
	endproperty
	a_qual: assert property (p_qual) else $error("unqualified drive"); // [R11]

	property p_end;
		@(posedge clk_sys) disable iff (!rst_s2_q)
		$rose(tx_s2_q) |=> xmit_q [*8];
	endproperty
	a_end: assert property (p_end) else $error("transmission end early"); // [R12]

	property p_col;
		@(posedge clk_sys) disable iff (!rst_s2_q)
		col_s2_q |-> ##[1:11] (collision_out_pair || collision_out_pair_n);
	endproperty
	a_col: assert property (p_col) else $error("no collision"); // [R1]

	property p_restart;
		@(posedge clk_sys) disable iff (!rst_s2_q)
		(jb_q == CHJC_JB_RUN && !xmit_q) |=> jb_cnt_q == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("jabber count kept"); // [R14]
endmodule : chjc_top

// >>> verif/chjc_dte_model.sv
/*
 Terminal-side partner model: drives transmit activity, watches the collision pair.
 Assumes the bench calls clear_obs and send from its falling-edge stimulus.
*/
`timescale 1ns/1ps
module chjc_dte_model (
	input  wire logic clk_sys,              // System clock
	input  wire logic collision_out_pair,   // Collision pair, positive leg
	input  wire logic collision_out_pair_n, // Collision pair, negative leg
	output logic      tx_active_in,         // Transmit activity toward block
	output int        act_cnt,              // Cycles with pair not at rest
	output int        rise_cnt,             // Rising edges on positive leg
	output int        first_act             // Cycle of first activity since clear
);
	int   cyc;
	logic prev_q;
	initial begin
		tx_active_in = 1'b0;
		cyc = 0;
		prev_q = 1'b0;
		act_cnt = 0;
		rise_cnt = 0;
		first_act = -1;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (collision_out_pair !== collision_out_pair_n) begin
			act_cnt++;
			if (first_act < 0) first_act = cyc;
		end
		if (collision_out_pair && !prev_q) rise_cnt++;
		prev_q = collision_out_pair;
	end
	task automatic clear_obs;
		cyc = 0;
		act_cnt = 0;
		rise_cnt = 0;
		first_act = -1;
	endtask : clear_obs
	// Transmit stays idle between frames
	task automatic send(input int len);
		tx_active_in = 1'b1;
		repeat (len) @(negedge clk_sys);
		tx_active_in = 1'b0;
	endtask : send
endmodule : chjc_dte_model

// >>> verif/tb.sv
/*
 Self-checking bench for the collision, heartbeat and jabber block.
 Assumes 100 MHz clock; jabber intervals are too long for this run.
*/
`timescale 1ns/1ps
module tb;
	import chjc_pkg::*;
	logic clk_sys, rst_n, tx_active_in, collision_cmp_in, heartbeat_enable_pin;
	logic coax_drive_out, collision_out_pair, collision_out_pair_n, jabber_fault_q;
	int   act_cnt, rise_cnt, first_act, err_total, total_checks;
	chjc_top chjc_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .tx_active_in(tx_active_in),
		.collision_cmp_in(collision_cmp_in), .heartbeat_enable_pin(heartbeat_enable_pin),
		.coax_drive_out(coax_drive_out), .collision_out_pair(collision_out_pair),
		.collision_out_pair_n(collision_out_pair_n), .jabber_fault_q(jabber_fault_q));
	chjc_dte_model chjc_dte_model_i (.clk_sys(clk_sys), .collision_out_pair(collision_out_pair),
		.collision_out_pair_n(collision_out_pair_n), .tx_active_in(tx_active_in),
		.act_cnt(act_cnt), .rise_cnt(rise_cnt), .first_act(first_act));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic t_idle;
		check({coax_drive_out, collision_out_pair, collision_out_pair_n, jabber_fault_q}, 4'h0);
		$display("Test idle done");
	endtask : t_idle
	// One frame, then watch the pair for a heartbeat burst
	task automatic t_frame(input logic hb_en);
		heartbeat_enable_pin = hb_en;
		repeat (4) @(negedge clk_sys);
		chjc_dte_model_i.send(50);
		check(coax_drive_out, 1'b1);
		chjc_dte_model_i.clear_obs();
		repeat (5) @(negedge clk_sys);
		check(coax_drive_out, 1'b0);
		repeat (300) @(negedge clk_sys);
		if (hb_en) begin
			check(first_act >= HB_DELAY_CYC - 5 && first_act <= HB_DELAY_CYC + 20, 1'b1);
			check(act_cnt >= HB_WIDTH_CYC - 5 && act_cnt <= HB_WIDTH_CYC + 5, 1'b1);
			check(rise_cnt >= 9 && rise_cnt <= 11, 1'b1);
		end else begin
			check(act_cnt, 32'h0);
		end
		check({collision_out_pair, collision_out_pair_n}, 2'h0);
		$display("Test frame with heartbeat %0d done", hb_en);
	endtask : t_frame
	task automatic t_collision;
		collision_cmp_in = 1'b1;
		chjc_dte_model_i.clear_obs();
		repeat (60) @(negedge clk_sys);
		check(act_cnt >= 46, 1'b1);
		check(rise_cnt >= 4 && rise_cnt <= 7, 1'b1);
		collision_cmp_in = 1'b0;
		repeat (20) @(negedge clk_sys);
		check({collision_out_pair, collision_out_pair_n, jabber_fault_q}, 3'h0);
		$display("Test collision done");
	endtask : t_collision
	initial begin
		err_total = 0;
		total_checks = 0;
		rst_n = 1'b0;
		collision_cmp_in = 1'b0;
		heartbeat_enable_pin = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		t_idle();
		t_frame(1'b1);
		t_frame(1'b0);
		t_collision();
		t_frame(1'b1);
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		close_out();
	end
endmodule : tb
